//--- shared/fcsc_consts.svh
// Offsets, fields, reset values and command codes of the flash command block
// Notes on behaviour
// - Writing 1 to buffer-empty bit 7 launches the staged command and clears it.
// - Buffer-empty clears when a burst is queued; sets again once buffer frees.
// - One buffered command at most; only burst program may queue, and only behind a running burst.
// - Complete bit 6 set when idle with empty buffer; cleared by launch; read only.
// - Erase or program into protected block is ignored and sets violation bit 5.
// - Violation flag stays set until software writes 1 to it.
// - Access error bit 4: broken sequence, illegal code, divider not set for program or erase, launch refused while busy, or stop during command.
// - Access error clears only on a written 1; a written 0 does nothing.
// - Blank check sets blank bit 2 only when whole array reads erased.
// - Blank flag clears on a valid launch; software writes to it are ignored.
// - Status bits 3, 1, 0 read zero; other five readable anytime.
// - Command field is 8 bits with five legal codes; blank check is 0x05.
// - Code 0x20 programs one byte, 0x25 programs one byte in burst mode.
// - Code 0x40 erases the 512-byte page holding the address.
// - Code 0x41 erases the whole array.
// - Any other code is rejected and raises access error.
// - Unless protection disabled, top block sized by 3-bit select is protected.
// - With key writes disabled, backdoor key addresses start normal sequences.
`ifndef FCSC_CONSTS_SVH
`define FCSC_CONSTS_SVH
`define FCSC_OFF_STAT 4'h0
`define FCSC_OFF_CMD 4'h4
`define FCSC_OFF_ARR 4'h8
`define FCSC_OFF_CFG 4'hc
`define FCSC_BIT_CBE 7
`define FCSC_BIT_CCF 6
`define FCSC_BIT_PV 5
`define FCSC_BIT_AE 4
`define FCSC_BIT_BLK 2
`define FCSC_CMD_BLANK 8'h05
`define FCSC_CMD_BYTE 8'h20
`define FCSC_CMD_BURST 8'h25
`define FCSC_CMD_PAGE 8'h40
`define FCSC_CMD_MASS 8'h41
`define FCSC_KEY_LO 16'hffb0
`define FCSC_KEY_HI 16'hffb7
`define FCSC_PROT_FULL 16'h182c
`define FCSC_CFG_RST 6'h00
`define FCSC_RESP_OK 2'b00
`define FCSC_RESP_DEC 2'b11
`endif

//--- shared/fcsc_pkg.sv
// Types shared by the flash command block
package fcsc_pkg;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_DATA, SEQ_CMD} fcsc_seq_t;
	typedef struct packed {
		logic [7:0]  cmd;
		logic [15:0] addr;
		logic [7:0]  data;
	} fcsc_req_t;
endpackage : fcsc_pkg

//--- core/fcsc_top.sv
// Flash command and status controller with AXI4-Lite register slave
`timescale 1ns/1ps
`include "fcsc_consts.svh"
module fcsc_top import fcsc_pkg::*; (
	input  wire logic        clock_i,
	input  wire logic        resetn_i,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	input  wire logic        stop_mode_i,
	output logic             arr_start_o,
	output fcsc_req_t        arr_req_o,
	output logic             arr_abort_o,
	input  wire logic        arr_done_i,
	input  wire logic        arr_blank_i
);
	logic        aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [3:0]  aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic        w_lane_reg, w_lane_next;
	logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        wr_fire, wr_map, rd_map;
	logic [3:0]  ar_off;

	fcsc_seq_t   seq_reg, seq_next;
	logic        cbe_reg, cbe_next, ccf_reg, ccf_next;
	logic        pv_reg, pv_next, ae_reg, ae_next, blk_reg, blk_next;
	logic        busy_reg, busy_next, pend_reg, pend_next;
	fcsc_req_t   stage_reg, stage_next, pendq_reg, pendq_next;
	fcsc_req_t   cur_reg, cur_next;
	logic [5:0]  cfg_reg, cfg_next;
	logic        start_reg, start_next, abort_reg, abort_next;
	logic [7:0]  stat_word;
	logic        wr_stat, wr_cmd, wr_arr, wr_cfg, launch;
	logic        code_ok, is_pe, prot_hit, key_hole;

	// cfg: [0] divider set, [1] protection_disable, [4:2] size select,
	// [5] key_write_enable
	function automatic logic [15:0] prot_base(input logic [2:0] sel);
		case (sel)
			3'h0: prot_base = 16'hfe00;
			3'h1: prot_base = 16'hfc00;
			3'h2: prot_base = 16'hf800;
			3'h3: prot_base = 16'hf000;
			3'h4: prot_base = 16'he000;
			3'h5: prot_base = 16'hc000;
			3'h6: prot_base = 16'h8000;
			default: prot_base = `FCSC_PROT_FULL;
		endcase
	endfunction : prot_base

	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready  = !w_have_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign arr_start_o   = start_reg;
	assign arr_req_o     = cur_reg;
	assign arr_abort_o   = abort_reg;

	assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
	assign wr_map  = (aw_addr_reg[1:0] == 2'b00);
	assign ar_off  = s_axi_araddr[3:0];
	assign rd_map  = (s_axi_araddr[31:4] == 28'h0) && (ar_off[1:0] == 2'b00);

	assign stat_word = {cbe_reg, ccf_reg, pv_reg, ae_reg, 1'b0, blk_reg, 2'b00};

	// Bus slave: address and data captured in either order
	always_comb begin
		aw_have_next = aw_have_reg;
		aw_addr_next = aw_addr_reg;
		w_have_next  = w_have_reg;
		w_data_next  = w_data_reg;
		w_lane_next  = w_lane_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_next = 1'b1;
			aw_addr_next = (s_axi_awaddr[31:4] == 28'h0) ? s_axi_awaddr[3:0] : 4'h3;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_lane_next = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_map ? `FCSC_RESP_OK : `FCSC_RESP_DEC;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next  = rd_map ? `FCSC_RESP_OK : `FCSC_RESP_DEC;
			rdata_next  = 32'h0;
			if (rd_map) begin
				case (ar_off)
					`FCSC_OFF_STAT: rdata_next = {24'h0, stat_word};
					`FCSC_OFF_CMD: rdata_next = {24'h0, stage_reg.cmd};
					`FCSC_OFF_ARR: rdata_next = {stage_reg.addr, 8'h0, stage_reg.data};
					default: rdata_next = {26'h0, cfg_reg};
				endcase
			end
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_have_reg  <= 1'b0;
			w_data_reg  <= 32'h0;
			w_lane_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'b00;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= 2'b00;
		end else begin
			aw_have_reg <= aw_have_next;
			aw_addr_reg <= aw_addr_next;
			w_have_reg  <= w_have_next;
			w_data_reg  <= w_data_next;
			w_lane_reg  <= w_lane_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	// Register effects need byte lane 0; other lanes alone are accepted and dropped
	assign wr_stat = wr_fire && w_lane_reg && aw_addr_reg == `FCSC_OFF_STAT;
	assign wr_cmd  = wr_fire && w_lane_reg && aw_addr_reg == `FCSC_OFF_CMD;
	assign wr_cfg  = wr_fire && w_lane_reg && aw_addr_reg == `FCSC_OFF_CFG;
	assign key_hole = cfg_reg[5] && w_data_reg[31:16] >= `FCSC_KEY_LO
		&& w_data_reg[31:16] <= `FCSC_KEY_HI;
	assign wr_arr  = wr_fire && w_lane_reg && aw_addr_reg == `FCSC_OFF_ARR && !key_hole;
	assign launch  = wr_stat && w_data_reg[`FCSC_BIT_CBE];

	always_comb begin
		code_ok = 1'b0;
		is_pe   = 1'b1;
		case (stage_reg.cmd)
			`FCSC_CMD_BLANK: begin
				code_ok = 1'b1;
				is_pe   = 1'b0;
			end
			`FCSC_CMD_BYTE, `FCSC_CMD_BURST, `FCSC_CMD_PAGE, `FCSC_CMD_MASS: code_ok = 1'b1;
			default: code_ok = 1'b0;
		endcase
	end

	// protected block; a page hits if its last byte reaches the block
	always_comb begin
		prot_hit = 1'b0;
		if (!cfg_reg[1]) begin
			case (stage_reg.cmd)
				`FCSC_CMD_MASS: prot_hit = 1'b1;
				`FCSC_CMD_PAGE: prot_hit = {stage_reg.addr[15:9], 9'h1ff} >= prot_base(cfg_reg[4:2]);
				`FCSC_CMD_BYTE, `FCSC_CMD_BURST: prot_hit = stage_reg.addr >= prot_base(cfg_reg[4:2]);
				default: prot_hit = 1'b0;
			endcase
		end
	end

	always_comb begin
		seq_next   = seq_reg;
		pv_next    = pv_reg;
		ae_next    = ae_reg;
		blk_next   = blk_reg;
		busy_next  = busy_reg;
		pend_next  = pend_reg;
		stage_next = stage_reg;
		pendq_next = pendq_reg;
		cur_next   = cur_reg;
		cfg_next   = cfg_reg;
		start_next = 1'b0;
		abort_next = 1'b0;
		// clear by one; a set below overrides
		if (wr_stat && w_data_reg[`FCSC_BIT_PV])
			pv_next = 1'b0;
		if (wr_stat && w_data_reg[`FCSC_BIT_AE])
			ae_next = 1'b0;
		if (wr_cfg)
			cfg_next = w_data_reg[5:0];
		// blank result at end of check
		if (busy_reg && arr_done_i) begin
			if (cur_reg.cmd == `FCSC_CMD_BLANK)
				blk_next = arr_blank_i;
			if (pend_reg) begin
				cur_next   = pendq_reg;
				pend_next  = 1'b0;
				start_next = 1'b1;
			end else begin
				busy_next = 1'b0;
			end
		end
		if (wr_arr) begin
			if (seq_reg == SEQ_IDLE && cbe_reg) begin
				seq_next        = SEQ_DATA;
				stage_next.addr = w_data_reg[31:16];
				stage_next.data = w_data_reg[7:0];
			end else begin
				seq_next = SEQ_IDLE;
				ae_next  = 1'b1;
			end
		end
		if (wr_cmd) begin
			if (seq_reg == SEQ_DATA) begin
				seq_next       = SEQ_CMD;
				stage_next.cmd = w_data_reg[7:0];
			end else begin
				seq_next = SEQ_IDLE;
				ae_next  = 1'b1;
			end
		end
		if (launch) begin
			seq_next = SEQ_IDLE;
			// checks in order; rejected commands change nothing else
			if (seq_reg != SEQ_CMD || !cbe_reg || !code_ok)
				ae_next = 1'b1;
			else if (is_pe && !cfg_reg[0])
				ae_next = 1'b1;
			else if (prot_hit)
				pv_next = 1'b1;
			else if (busy_next && !(stage_reg.cmd == `FCSC_CMD_BURST
				&& cur_next.cmd == `FCSC_CMD_BURST))
				ae_next = 1'b1;
			else begin
				blk_next = 1'b0;
				if (busy_next) begin
					pend_next  = 1'b1;
					pendq_next = stage_reg;
				end else begin
					busy_next  = 1'b1;
					cur_next   = stage_reg;
					start_next = 1'b1;
				end
			end
		end
		// stop during a command aborts it
		if (stop_mode_i && busy_reg) begin
			ae_next    = 1'b1;
			busy_next  = 1'b0;
			pend_next  = 1'b0;
			start_next = 1'b0;
			abort_next = 1'b1;
		end
		cbe_next = !pend_next && !launch;
		ccf_next = !pend_next && !busy_next && !launch;
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			seq_reg   <= SEQ_IDLE;
			cbe_reg   <= 1'b1;
			ccf_reg   <= 1'b1;
			pv_reg    <= 1'b0;
			ae_reg    <= 1'b0;
			blk_reg   <= 1'b0;
			busy_reg  <= 1'b0;
			pend_reg  <= 1'b0;
			stage_reg <= '0;
			pendq_reg <= '0;
			cur_reg   <= '0;
			cfg_reg   <= `FCSC_CFG_RST;
			start_reg <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			seq_reg   <= seq_next;
			cbe_reg   <= cbe_next;
			ccf_reg   <= ccf_next;
			pv_reg    <= pv_next;
			ae_reg    <= ae_next;
			blk_reg   <= blk_next;
			busy_reg  <= busy_next;
			pend_reg  <= pend_next;
			stage_reg <= stage_next;
			pendq_reg <= pendq_next;
			cur_reg   <= cur_next;
			cfg_reg   <= cfg_next;
			start_reg <= start_next;
			abort_reg <= abort_next;
		end
	end

	logic rd_stat_reg;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i)
			rd_stat_reg <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			rd_stat_reg <= rd_map && ar_off == `FCSC_OFF_STAT;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	launch_cbe_a: assert property (launch |=> !cbe_reg && !ccf_reg)
		else $error("launch did not clear buffer-empty and complete");
	queue_one_a: assert property (pend_reg |-> busy_reg && pendq_reg.cmd == `FCSC_CMD_BURST)
		else $error("buffered command is not a burst behind work");
	ccf_idle_a: assert property (ccf_reg |-> !busy_reg && !pend_reg && cbe_reg)
		else $error("complete set while work remains");
	prot_block_a: assert property (launch && seq_reg == SEQ_CMD && cbe_reg && code_ok
		&& !(is_pe && !cfg_reg[0]) && prot_hit |=> pv_reg && !start_reg)
		else $error("protected command not refused");
	pv_hold_a: assert property (pv_reg && !(wr_stat && w_data_reg[`FCSC_BIT_PV]) |=> pv_reg)
		else $error("violation flag dropped without a clear");
	nodiv_err_a: assert property (launch && seq_reg == SEQ_CMD && cbe_reg && code_ok
		&& is_pe && !cfg_reg[0] |=> ae_reg && !start_reg)
		else $error("program before divider set not refused");
	ae_hold_a: assert property (ae_reg && !(wr_stat && w_data_reg[`FCSC_BIT_AE]) |=> ae_reg)
		else $error("access error dropped without a clear");
	blank_keep_a: assert property (!launch && !(busy_reg && arr_done_i) |=> $stable(blk_reg))
		else $error("blank flag moved without cause");
	stat_zero_a: assert property (rvalid_reg && rd_stat_reg |-> (rdata_reg & 32'hffff_ff0b) == 32'h0)
		else $error("reserved status bits not zero");
	illegal_err_a: assert property (launch && seq_reg == SEQ_CMD && cbe_reg && !code_ok
		|=> ae_reg && !start_reg)
		else $error("illegal code not refused");
	seq_err_a: assert property (wr_cmd && seq_reg != SEQ_DATA |=> ae_reg && seq_reg == SEQ_IDLE)
		else $error("out of order command write not flagged");

	burst_queue_c: cover property (launch && busy_reg ##1 pend_reg);
	blank_pass_c: cover property (busy_reg && arr_done_i && cur_reg.cmd == `FCSC_CMD_BLANK && arr_blank_i);
	stop_abort_c: cover property (abort_reg);
endmodule : fcsc_top

//--- testbench/fcsc_array_model.sv
// Behavioural flash array answering the command block
`timescale 1ns/1ps
module fcsc_array_model import fcsc_pkg::*; #(
	parameter int BUSY_CYCLES = 60
) (
	input  wire logic       clock_i,
	input  wire logic       resetn_i,
	input  wire logic       start_i,
	input  wire fcsc_req_t  req_i,
	input  wire logic       abort_i,
	output logic            done_o,
	output logic            blank_o,
	output logic [7:0]      starts_o,
	output logic [7:0]      last_cmd_o
);
	logic [7:0] count_reg;
	logic       erased_reg;
	logic       toggle_reg;

	// Blank is only valid with done; otherwise it wanders so stale reads show
	assign blank_o = done_o ? erased_reg : toggle_reg;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_reg  <= 8'h00;
			erased_reg <= 1'b0;
			toggle_reg <= 1'b0;
			done_o     <= 1'b0;
			starts_o   <= 8'h00;
			last_cmd_o <= 8'h00;
		end else begin
			done_o     <= 1'b0;
			toggle_reg <= ~toggle_reg;
			if (abort_i) begin
				count_reg <= 8'h00;
			end else if (start_i) begin
				count_reg  <= 8'(BUSY_CYCLES);
				starts_o   <= starts_o + 8'h01;
				last_cmd_o <= req_i.cmd;
			end else if (count_reg != 8'h00) begin
				count_reg <= count_reg - 8'h01;
				if (count_reg == 8'h01) begin
					done_o <= 1'b1;
					if (last_cmd_o == 8'h41) begin
						erased_reg <= 1'b1;
					end else if (last_cmd_o[7:4] == 4'h2) begin
						erased_reg <= 1'b0;
					end
				end
			end
		end
	end
endmodule : fcsc_array_model

//--- testbench/test_flash_command_status_controller.sv
// Register-level test of the flash command block
`timescale 1ns/1ps
`include "fcsc_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_flash_command_status_controller;
	localparam logic [31:0] A_STAT = {28'h0, `FCSC_OFF_STAT};
	localparam logic [31:0] A_CMD  = {28'h0, `FCSC_OFF_CMD};
	localparam logic [31:0] A_ARR  = {28'h0, `FCSC_OFF_ARR};
	localparam logic [31:0] A_CFG  = {28'h0, `FCSC_OFF_CFG};
	localparam logic [7:0]  CODES [6] = '{8'h41, 8'h05, 8'h20, 8'h05, 8'h40, 8'h25};
	localparam logic [7:0]  EXPS  [6] = '{8'hc0, 8'hc4, 8'hc0, 8'hc0, 8'hc0, 8'hc0};
	logic                clock_i, resetn_i, awvalid, awready, wvalid, wready, bvalid, bready;
	logic                arvalid, arready, rvalid, rready, stop_mode, start, abort, done, blank;
	logic [31:0]         awaddr, wdata, araddr, rdata, r;
	logic [1:0]          bresp, rresp;
	logic [7:0]          starts, last_cmd;
	fcsc_pkg::fcsc_req_t req;
	int                  fails, compares, cyc, aborts;

	fcsc_top u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .stop_mode_i(stop_mode),
		.arr_start_o(start), .arr_req_o(req), .arr_abort_o(abort), .arr_done_i(done), .arr_blank_i(blank));

	fcsc_array_model u_array (.clock_i(clock_i), .resetn_i(resetn_i), .start_i(start), .req_i(req),
		.abort_i(abort), .done_o(done), .blank_o(blank), .starts_o(starts), .last_cmd_o(last_cmd));

	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	task report_and_stop;
		begin
			if (fails == 0 && compares > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask : report_and_stop

	// Hang guard well above the roughly one thousand cycles the tests need
	always @(posedge clock_i) begin
		cyc++;
		// Abort is a one-cycle pulse, so count it where it stands
		if (abort === 1'b1)
			aborts++;
		if (cyc == 20000) begin
			fails++;
			report_and_stop;
		end
	end

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic ta, tw, na, nw;
		begin
			ta = 1'b0;
			tw = 1'b0;
			@(posedge clock_i);
			awaddr  <= a;
			wdata   <= d;
			awvalid <= 1'b1;
			wvalid  <= 1'b1;
			bready  <= 1'b1;
			while (!(ta && tw)) begin
				@(negedge clock_i);
				na = awvalid & awready;
				nw = wvalid & wready;
				@(posedge clock_i);
				if (na) begin
					awvalid <= 1'b0;
					ta = 1'b1;
				end
				if (nw) begin
					wvalid <= 1'b0;
					tw = 1'b1;
				end
			end
			do @(negedge clock_i); while (!bvalid);
			`CHK(bresp, `FCSC_RESP_OK)
			@(posedge clock_i);
			bready <= 1'b0;
		end
	endtask : wr

	task automatic rd(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er);
		begin
			@(posedge clock_i);
			araddr  <= a;
			arvalid <= 1'b1;
			rready  <= 1'b1;
			do @(negedge clock_i); while (!(arvalid && arready));
			@(posedge clock_i);
			arvalid <= 1'b0;
			do @(negedge clock_i); while (!rvalid);
			d = rdata;
			`CHK(rresp, er)
			@(posedge clock_i);
			rready <= 1'b0;
		end
	endtask : rd

	task automatic chk_stat(input logic [7:0] e);
		begin
			rd(A_STAT, r, `FCSC_RESP_OK);
			`CHK(r, {24'h0, e})
		end
	endtask : chk_stat

	task automatic seq(input logic [15:0] a, input logic [7:0] code);
		begin
			wr(A_ARR, {a, 16'h005a});
			wr(A_CMD, {24'h0, code});
			wr(A_STAT, 32'h80);
		end
	endtask : seq

	task automatic wait_idle;
		begin
			do rd(A_STAT, r, `FCSC_RESP_OK); while (r[6] !== 1'b1);
		end
	endtask : wait_idle

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, stop_mode} = 6'h00;
		{awaddr, wdata, araddr} = 96'h0;
		fails = 0;
		compares = 0;
		cyc = 0;
		aborts = 0;
		resetn_i = 1'b0;
		repeat (16) @(posedge clock_i);
		resetn_i <= 1'b1;
		chk_stat(8'hc0);
		wr(A_STAT, 32'hff);
		chk_stat(8'hd0);
		wr(A_STAT, 32'h00);
		chk_stat(8'hd0);
		wr(A_STAT, 32'h10);
		chk_stat(8'hc0);
		rd(32'h10, r, `FCSC_RESP_DEC);
		`CHK(r, 32'h0)
		seq(16'h1000, `FCSC_CMD_BYTE);
		chk_stat(8'hd0);
		wr(A_STAT, 32'h10);
		wr(A_CFG, 32'h01);
		seq(16'hfe10, `FCSC_CMD_BYTE);
		chk_stat(8'he0);
		wr(A_STAT, 32'h20);
		chk_stat(8'hc0);
		seq(16'h1000, 8'h33);
		chk_stat(8'hd0);
		wr(A_STAT, 32'h10);
		wr(A_CFG, 32'h03);
		for (int i = 0; i < 6; i++) begin
			seq(16'h1000, CODES[i]);
			wait_idle;
			chk_stat(EXPS[i]);
			`CHK(last_cmd, CODES[i])
		end
		`CHK(starts, 8'h06)
		`CHK(req, {`FCSC_CMD_BURST, 16'h1000, 8'h5a})
		// Second burst queues while the first one is still busy
		seq(16'h1001, `FCSC_CMD_BURST);
		seq(16'h1002, `FCSC_CMD_BURST);
		chk_stat(8'h00);
		wait_idle;
		`CHK(starts, 8'h08)
		seq(16'h1003, `FCSC_CMD_BURST);
		seq(16'h1004, `FCSC_CMD_BYTE);
		chk_stat(8'h90);
		wait_idle;
		wr(A_STAT, 32'h10);
		seq(16'h1200, `FCSC_CMD_PAGE);
		@(posedge clock_i);
		stop_mode <= 1'b1;
		repeat (3) @(posedge clock_i);
		stop_mode <= 1'b0;
		chk_stat(8'hd0);
		`CHK(starts, 8'h0a)
		`CHK(aborts, 1)
		// Key writes enabled: the array write is swallowed, so the command write is out of order
		wr(A_STAT, 32'h10);
		wr(A_CFG, 32'h23);
		wr(A_ARR, 32'hffb0_005a);
		wr(A_CMD, {24'h0, `FCSC_CMD_BLANK});
		chk_stat(8'hd0);
		rd(A_CMD, r, `FCSC_RESP_OK);
		`CHK(r, {24'h0, `FCSC_CMD_PAGE})
		rd(A_ARR, r, `FCSC_RESP_OK);
		`CHK(r, 32'h1200_005a)
		// Key writes disabled: the same address starts a normal sequence
		wr(A_STAT, 32'h10);
		wr(A_CFG, 32'h03);
		seq(16'hffb0, `FCSC_CMD_BLANK);
		wait_idle;
		chk_stat(8'hc0);
		`CHK(starts, 8'h0b)
		`CHK(last_cmd, `FCSC_CMD_BLANK)
		`CHK(req, {`FCSC_CMD_BLANK, 16'hffb0, 8'h5a})
		report_and_stop;
	end
endmodule : test_flash_command_status_controller
